// [rtl/irs_defines.vh]
`ifndef IRS_DEFINES_VH
`define IRS_DEFINES_VH

// Register byte offsets
`define IRS_OFF_RUN_CONFIG     8'h00
`define IRS_OFF_CONTROL        8'h04
`define IRS_OFF_OUTPUT_MODE    8'h80
`define IRS_OFF_RGB_BASE_A     8'h84
`define IRS_OFF_RGB_BASE_B     8'h88
`define IRS_OFF_DEBUG_CONFIG   8'h90
`define IRS_OFF_MAX_WORKMEM    8'hB0
`define IRS_OFF_INPUT_PROG     8'hB8
`define IRS_OFF_HORIZ_PROG     8'hBC
`define IRS_OFF_VERT_PROG      8'hC0
`define IRS_OFF_COLOR_PROG     8'hC4
`define IRS_OFF_LUMA_BASE      8'hD0
`define IRS_OFF_CHROMA_U_BASE  8'hD4
`define IRS_OFF_CHROMA_V_BASE  8'hD8

// Debug configuration fields
`define IRS_DBG_PW_HI          31
`define IRS_DBG_PW_LO          28
`define IRS_DBG_OVERRUN_SELF_RESET_EN_BIT    12
`define IRS_DBG_DBLBUF_BIT     11
`define IRS_DBG_FHORIZ_BIT     10
`define IRS_DBG_FVERT_BIT      9
`define IRS_DBG_RESET          32'h00000200

// Control, mode and run configuration fields
`define IRS_CTL_ENABLE_BIT     0
`define IRS_MODE_YUV_BIT       0
`define IRS_CONT_BIT           4

// Address masks: RGB half-word, YUV word aligned
`define IRS_RGB_MASK           32'hFFFFFFFE
`define IRS_YUV_MASK           32'hFFFFFFFC
`define IRS_ZERO32             32'h00000000
`define IRS_ZERO16             16'h0000
`define IRS_ONE16              16'h0001

`endif

// [rtl/irs_pulse_gen.v]
`timescale 1ns/10ps
`default_nettype none

// Self-reset pulse stretcher: width is field value plus one cycle
module irs_pulse_gen #(
  parameter W = 4
) (
  input  wire         clk,
  input  wire         rst,
  input  wire         trig,
  input  wire [W-1:0] width,
  output reg          pulse
);

  reg [W-1:0] cnt_reg;

  // Count down while the pulse is high
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= {W{1'b0}};
      pulse   <= 1'b0;
    end else if (trig) begin
      cnt_reg <= width;
      pulse   <= 1'b1;
    end else if (cnt_reg != {W{1'b0}}) begin
      cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
    end else begin
      pulse <= 1'b0;
    end
  end

endmodule // irs_pulse_gen

`default_nettype wire

// [rtl/irs_progress.v]
`timescale 1ns/10ps
`default_nettype none

// Two-axis progress counter: x steps, line wraps x and steps y
module irs_progress #(
  parameter W = 16
) (
  input  wire         clk,
  input  wire         rst,
  input  wire         clear,
  input  wire         step,
  input  wire         line_end,
  output reg  [W-1:0] x_cnt,
  output reg  [W-1:0] y_cnt
);

  // Clear has priority so a restart starts from zero
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      x_cnt <= {W{1'b0}};
      y_cnt <= {W{1'b0}};
    end else if (clear) begin
      x_cnt <= {W{1'b0}};
      y_cnt <= {W{1'b0}};
    end else if (line_end) begin
      x_cnt <= {W{1'b0}};
      y_cnt <= y_cnt + {{(W-1){1'b0}}, 1'b1};
    end else if (step) begin
      x_cnt <= x_cnt + {{(W-1){1'b0}}, 1'b1};
    end
  end

endmodule // irs_progress

`default_nettype wire

// [rtl/irs_regs.v]
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
`include "irs_defines.vh"

module irs_regs (
  input  wire        sys_clk,
  input  wire        rst,
  // Avalon-MM slave
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  output reg  [1:0]  avs_response,
  // Datapath events
  input  wire        vsync,
  input  wire        frame_start,
  input  wire        frame_done,
  input  wire        in_pixel,
  input  wire        in_line_end,
  input  wire        hr_step,
  input  wire        hr_line_end,
  input  wire        vr_step,
  input  wire        vr_line_end,
  input  wire        cc_step,
  input  wire        cc_line_end,
  input  wire [15:0] workmem_used,
  // Effective settings toward the datapath
  output reg         scaler_enable,
  output reg         continuous_run,
  output reg         yuv_mode,
  output reg  [31:0] frame_target_base,
  output reg  [31:0] luma_base_out,
  output reg  [31:0] chroma_u_base_out,
  output reg  [31:0] chroma_v_base_out,
  output reg         force_vertical_pass,
  output reg         force_horizontal_pass,
  output reg         self_reset
);

  // Shadow (written) copies
  reg [31:0] run_config_reg;
  reg [31:0] control_reg;
  reg [31:0] mode_reg;
  reg [31:0] base_a_reg;
  reg [31:0] base_b_reg;
  reg [31:0] dbg_reg;
  reg [31:0] luma_reg;
  reg [31:0] cu_reg;
  reg [31:0] cv_reg;
  // Active copies seen by the datapath
  reg [31:0] act_mode_reg;
  reg [31:0] act_a_reg;
  reg [31:0] act_b_reg;
  reg [31:0] act_luma_reg;
  reg [31:0] act_cu_reg;
  reg [31:0] act_cv_reg;
  reg        buf_sel_reg;
  reg        busy_reg;
  reg [15:0] peak_reg;
  reg        ack_reg;
  reg [31:0] rdata_next;
  reg        hit_next;

  // Writes land at the answer edge, where the master sees waitrequest low
  wire        wr_go  = avs_write & ack_reg;
  wire        rd_go  = avs_read & ~ack_reg;
  wire        ctl_wr = wr_go && (avs_address == `IRS_OFF_CONTROL);
  wire        new_en = ctl_wr && avs_writedata[`IRS_CTL_ENABLE_BIT];
  wire        dbl    = dbg_reg[`IRS_DBG_DBLBUF_BIT];
  wire        overrun;
  wire        pulse;
  wire [15:0] in_x;
  wire [15:0] in_y;
  wire [15:0] hr_x;
  wire [15:0] hr_y;
  wire [15:0] vr_x;
  wire [15:0] vr_y;
  wire [15:0] cc_x;
  wire [15:0] cc_y;

  // Byte-lane merge, used by every writable register
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  be;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (be[i])
          merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  // Apply point for shadow values
  // every cycle without double buffering, else vsync or enable
  wire apply = ~dbl | vsync | new_en;

  assign overrun = dbg_reg[`IRS_DBG_OVERRUN_SELF_RESET_EN_BIT] & frame_start & busy_reg;

  irs_pulse_gen #(.W(4)) u_pulse (
    .clk   (sys_clk),
    .rst   (rst),
    .trig  (overrun),
    .width (dbg_reg[`IRS_DBG_PW_HI:`IRS_DBG_PW_LO]),
    .pulse (pulse)
  );

  irs_progress #(.W(16)) u_in (
    .clk      (sys_clk),
    .rst      (rst),
    .clear    (frame_done | pulse),
    .step     (in_pixel),
    .line_end (in_line_end),
    .x_cnt    (in_x),
    .y_cnt    (in_y)
  );

  irs_progress #(.W(16)) u_hr (
    .clk      (sys_clk),
    .rst      (rst),
    .clear    (frame_start | pulse),
    .step     (hr_step),
    .line_end (hr_line_end),
    .x_cnt    (hr_x),
    .y_cnt    (hr_y)
  );

  irs_progress #(.W(16)) u_vr (
    .clk      (sys_clk),
    .rst      (rst),
    .clear    (frame_start | pulse),
    .step     (vr_step),
    .line_end (vr_line_end),
    .x_cnt    (vr_x),
    .y_cnt    (vr_y)
  );

  irs_progress #(.W(16)) u_cc (
    .clk      (sys_clk),
    .rst      (rst),
    .clear    (frame_start | pulse),
    .step     (cc_step),
    .line_end (cc_line_end),
    .x_cnt    (cc_x),
    .y_cnt    (cc_y)
  );

  // Software writes into shadow registers
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      run_config_reg <= `IRS_ZERO32;
      control_reg    <= `IRS_ZERO32;
      mode_reg       <= `IRS_ZERO32;
      base_a_reg     <= `IRS_ZERO32;
      base_b_reg     <= `IRS_ZERO32;
      dbg_reg        <= `IRS_DBG_RESET;
      luma_reg       <= `IRS_ZERO32;
      cu_reg         <= `IRS_ZERO32;
      cv_reg         <= `IRS_ZERO32;
    end else if (wr_go) begin
      case (avs_address)
        `IRS_OFF_RUN_CONFIG:    run_config_reg <= merge(run_config_reg, avs_writedata, avs_byteenable);
        `IRS_OFF_CONTROL:       control_reg <= merge(control_reg, avs_writedata, avs_byteenable);
        `IRS_OFF_OUTPUT_MODE:   mode_reg <= merge(mode_reg, avs_writedata, avs_byteenable);
        `IRS_OFF_RGB_BASE_A:    base_a_reg <= merge(base_a_reg, avs_writedata, avs_byteenable) & `IRS_RGB_MASK;
        `IRS_OFF_RGB_BASE_B:    base_b_reg <= merge(base_b_reg, avs_writedata, avs_byteenable) & `IRS_RGB_MASK;
        `IRS_OFF_DEBUG_CONFIG:  dbg_reg <= merge(dbg_reg, avs_writedata, avs_byteenable);
        `IRS_OFF_LUMA_BASE:     luma_reg <= merge(luma_reg, avs_writedata, avs_byteenable) & `IRS_YUV_MASK;
        `IRS_OFF_CHROMA_U_BASE: cu_reg <= merge(cu_reg, avs_writedata, avs_byteenable) & `IRS_YUV_MASK;
        `IRS_OFF_CHROMA_V_BASE: cv_reg <= merge(cv_reg, avs_writedata, avs_byteenable) & `IRS_YUV_MASK;
        default: ;
      endcase
    end
  end

  // Shadow to active transfer; debug bits act at once for debugging
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      act_mode_reg <= `IRS_ZERO32;
      act_a_reg    <= `IRS_ZERO32;
      act_b_reg    <= `IRS_ZERO32;
      act_luma_reg <= `IRS_ZERO32;
      act_cu_reg   <= `IRS_ZERO32;
      act_cv_reg   <= `IRS_ZERO32;
    end else if (apply) begin
      act_mode_reg <= mode_reg;
      act_a_reg    <= base_a_reg;
      act_b_reg    <= base_b_reg;
      act_luma_reg <= luma_reg;
      act_cu_reg   <= cu_reg;
      act_cv_reg   <= cv_reg;
    end
  end

  // Frame state, buffer ping-pong and peak memory
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy_reg    <= 1'b0;
      buf_sel_reg <= 1'b0;
      peak_reg    <= `IRS_ZERO16;
    end else begin
      if (pulse)
        busy_reg <= 1'b0;
      else if (frame_start)
        busy_reg <= 1'b1;
      else if (frame_done)
        busy_reg <= 1'b0;
      if (new_en)
        buf_sel_reg <= 1'b0;
      else if (frame_done)
        buf_sel_reg <= ~buf_sel_reg;
      if (new_en)
        peak_reg <= `IRS_ZERO16;
      else if (workmem_used > peak_reg)
        peak_reg <= workmem_used;
    end
  end

  // Registered outputs toward the datapath
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      scaler_enable         <= 1'b0;
      continuous_run        <= 1'b0;
      yuv_mode              <= 1'b0;
      frame_target_base     <= `IRS_ZERO32;
      luma_base_out         <= `IRS_ZERO32;
      chroma_u_base_out     <= `IRS_ZERO32;
      chroma_v_base_out     <= `IRS_ZERO32;
      force_vertical_pass   <= 1'b1;
      force_horizontal_pass <= 1'b0;
      self_reset            <= 1'b0;
    end else begin
      scaler_enable         <= control_reg[`IRS_CTL_ENABLE_BIT];
      continuous_run        <= run_config_reg[`IRS_CONT_BIT];
      yuv_mode              <= act_mode_reg[`IRS_MODE_YUV_BIT];
      frame_target_base     <= buf_sel_reg ? act_b_reg : act_a_reg;
      luma_base_out         <= act_mode_reg[`IRS_MODE_YUV_BIT] ? act_luma_reg : `IRS_ZERO32;
      chroma_u_base_out     <= act_mode_reg[`IRS_MODE_YUV_BIT] ? act_cu_reg : `IRS_ZERO32;
      chroma_v_base_out     <= act_mode_reg[`IRS_MODE_YUV_BIT] ? act_cv_reg : `IRS_ZERO32;
      force_vertical_pass   <= dbg_reg[`IRS_DBG_FVERT_BIT];
      force_horizontal_pass <= dbg_reg[`IRS_DBG_FHORIZ_BIT];
      self_reset            <= pulse;
    end
  end

  // Read decode
  always @* begin
    rdata_next = `IRS_ZERO32;
    hit_next   = 1'b1;
    case (avs_address)
      `IRS_OFF_RUN_CONFIG:    rdata_next = run_config_reg;
      `IRS_OFF_CONTROL:       rdata_next = control_reg;
      `IRS_OFF_OUTPUT_MODE:   rdata_next = mode_reg;
      `IRS_OFF_RGB_BASE_A:    rdata_next = base_a_reg;
      `IRS_OFF_RGB_BASE_B:    rdata_next = base_b_reg;
      `IRS_OFF_DEBUG_CONFIG:  rdata_next = dbg_reg;
      `IRS_OFF_MAX_WORKMEM:   rdata_next = {`IRS_ZERO16, peak_reg};
      `IRS_OFF_INPUT_PROG:    rdata_next = {in_y, in_x};
      `IRS_OFF_HORIZ_PROG:    rdata_next = {hr_x, hr_y};
      `IRS_OFF_VERT_PROG:     rdata_next = {vr_x, vr_y};
      `IRS_OFF_COLOR_PROG:    rdata_next = {cc_x, cc_y};
      `IRS_OFF_LUMA_BASE:     rdata_next = luma_reg;
      `IRS_OFF_CHROMA_U_BASE: rdata_next = cu_reg;
      `IRS_OFF_CHROMA_V_BASE: rdata_next = cv_reg;
      default:                hit_next = 1'b0;
    endcase
  end

  // Bus handshake: one wait cycle, answer on the second edge
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ack_reg         <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= `IRS_ZERO32;
      avs_response    <= 2'h0;
    end else if ((avs_read | avs_write) & ~ack_reg) begin
      ack_reg         <= 1'b1;
      avs_waitrequest <= 1'b0;
      avs_readdata    <= rd_go ? rdata_next : `IRS_ZERO32;
      avs_response    <= hit_next ? 2'h0 : 2'h3;
    end else begin
      ack_reg         <= 1'b0;
      avs_waitrequest <= 1'b1;
    end
  end

endmodule // irs_regs

`default_nettype wire

// [tb/irs_regs_chk.sv]
`timescale 1ns/10ps
`default_nettype none
module irs_regs_chk (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [1:0]  avs_response,
  input wire logic        frame_start,
  input wire logic        yuv_mode,
  input wire logic [31:0] luma_base_out,
  input wire logic        force_vertical_pass,
  input wire logic        force_horizontal_pass,
  input wire logic        self_reset
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Bus handshake: one wait cycle, answer stands one cycle
  ans_one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("bus answer late");
  ans_one_cycle_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer held too long");
  idle_wait_a: assert property (!(avs_read || avs_write) |-> avs_waitrequest)
    else $error("answer without request");
  unmapped_zero_a: assert property (!avs_waitrequest && avs_response == 2'h3
    |-> avs_readdata == 32'h00000000) else $error("unmapped read not zero");
  // Luma base word aligned, zero outside planar mode
  plane_off_zero_a: assert property (!yuv_mode ##1 !yuv_mode
    |-> luma_base_out == 32'h00000000) else $error("plane base outside mode");
  plane_align_a: assert property (luma_base_out[1:0] == 2'h0)
    else $error("plane base misaligned");
  // Self reset follows an overrun and ends within sixteen cycles
  reset_cause_a: assert property ($rose(self_reset)
    |-> $past(frame_start) || $past(frame_start, 2)) else $error("self reset uncaused");
  reset_len_a: assert property ($rose(self_reset) |-> ##[1:16] !self_reset)
    else $error("self reset too long");
  // Force bits move only after a debug config write
  force_v_src_a: assert property ($changed(force_vertical_pass)
    |-> $past(avs_write && avs_address == 8'h90, 2)) else $error("force vertical moved");
  force_h_src_a: assert property ($changed(force_horizontal_pass)
    |-> $past(avs_write && avs_address == 8'h90, 2)) else $error("force horizontal moved");
endmodule // irs_regs_chk

bind irs_regs irs_regs_chk chk (.sys_clk, .rst, .avs_address, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .avs_response, .frame_start, .yuv_mode,
  .luma_base_out, .force_vertical_pass, .force_horizontal_pass, .self_reset);
`default_nettype wire

// [tb/irs_src_model.sv]
`timescale 1ns/10ps
`default_nettype none
module irs_src_model (
  input  wire logic        sys_clk,
  output var  logic        vsync,
  output var  logic        frame_start,
  output var  logic        frame_done,
  output var  logic        step,
  output var  logic        line_end,
  output var  logic [15:0] workmem_used
);
  // Quiet source until asked
  initial begin
    vsync = 1'h0;
    frame_start = 1'h0;
    frame_done = 1'h0;
    step = 1'h0;
    line_end = 1'h0;
    workmem_used = 16'h0004;
  end
  // Vertical sync, one cycle
  task automatic vs;
    @(posedge sys_clk);
    vsync <= 1'h1;
    @(posedge sys_clk);
    vsync <= 1'h0;
  endtask
  // Full lines, then a partial line; line end on its own cycle
  // occupancy set to wm at frame start and held after
  task automatic frame(input int lines, input int pix, input logic done,
                       input logic [15:0] wm);
    @(posedge sys_clk);
    frame_start  <= 1'h1;
    workmem_used <= wm;
    @(posedge sys_clk);
    frame_start <= 1'h0;
    for (int l = 0; l <= lines; l++) begin
      step <= 1'h1;
      repeat (pix) @(posedge sys_clk);
      step     <= 1'h0;
      line_end <= (l < lines);
      @(posedge sys_clk);
      line_end <= 1'h0;
    end
    frame_done <= done;
    @(posedge sys_clk);
    frame_done <= 1'h0;
  endtask
endmodule // irs_src_model
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        sys_clk, rst, avs_read, avs_write, avs_waitrequest;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [1:0]  avs_response, r;
  logic        vsync, frame_start, frame_done, step, line_end;
  logic [15:0] workmem_used;
  logic        scaler_enable, continuous_run, yuv_mode, self_reset;
  logic        force_vertical_pass, force_horizontal_pass;
  logic [31:0] frame_target_base, luma_base_out, chroma_u_base_out, chroma_v_base_out;
  int          n_fail, comparisons, pulses, p;

  irs_regs dut (.sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .avs_response, .vsync,
    .frame_start, .frame_done, .in_pixel(step), .in_line_end(line_end), .hr_step(step),
    .hr_line_end(line_end), .vr_step(step), .vr_line_end(line_end), .cc_step(step),
    .cc_line_end(line_end), .workmem_used, .scaler_enable, .continuous_run, .yuv_mode,
    .frame_target_base, .luma_base_out, .chroma_u_base_out, .chroma_v_base_out,
    .force_vertical_pass, .force_horizontal_pass, .self_reset);
  irs_src_model src (.sys_clk, .vsync, .frame_start, .frame_done, .step, .line_end,
    .workmem_used);

  initial begin
    sys_clk = 1'h0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Count self reset cycles; width is read as a difference
  always @(posedge sys_clk) if (self_reset === 1'h1) pulses <= pulses + 1;

  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(string s, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", s, exp, seen);
    end
  endtask
  // Request held until waitrequest is seen low at an edge; the watchdog bounds the wait
  task automatic bus(logic [7:0] a, logic w, logic [31:0] d);
    @(posedge sys_clk);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= !w;
    avs_writedata <= d;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'h0);
    q = avs_readdata;
    r = avs_response;
    avs_read  <= 1'h0;
    avs_write <= 1'h0;
  endtask
  task automatic rchk(string s, logic [7:0] a, logic [31:0] e);
    bus(a, 1'h0, 32'h0);
    chk(s, q, e);
  endtask
  task automatic settle;
    repeat (3) @(posedge sys_clk);
  endtask

  // Bounded run; a hang ends as a failure
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    end_sim;
  end

  initial begin
    rst = 1'h1;
    avs_address = 8'h00;
    avs_read = 1'h0;
    avs_write = 1'h0;
    avs_writedata = 32'h0;
    n_fail = 0;
    comparisons = 0;
    pulses = 0;
    repeat (6) @(posedge sys_clk);
    rst <= 1'h0;
    rchk("debug reset", 8'h90, 32'h00000200);
    chk("force v", {31'h0, force_vertical_pass}, 32'h1);
    chk("force h", {31'h0, force_horizontal_pass}, 32'h0);
    bus(8'h40, 1'h0, 32'h0);
    chk("unmapped resp", {30'h0, r}, 32'h3);
    chk("unmapped data", q, 32'h0);
    $display("test reset done");
    src.frame(2, 4, 1'h0, 16'h0009);
    rchk("input", 8'hB8, 32'h00020004);
    for (int k = 0; k < 3; k++)
      rchk("progress", 8'hBC + 8'(4 * k), 32'h00040002);
    rchk("peak", 8'hB0, 32'h00000009);
    src.frame(0, 2, 1'h1, 16'h0005);
    rchk("input clear", 8'hB8, 32'h0);
    rchk("peak held", 8'hB0, 32'h00000009);
    chk("no self reset", pulses, 32'h0);
    $display("test progress done");
    bus(8'h00, 1'h1, 32'h10);
    bus(8'h84, 1'h1, 32'h1000);
    bus(8'h88, 1'h1, 32'h2000);
    for (int k = 0; k < 3; k++)
      bus(8'hD0 + 8'(4 * k), 1'h1, 32'h12345677 + (32'(k) << 8));
    bus(8'h80, 1'h1, 32'h1);
    bus(8'h04, 1'h1, 32'hF);
    settle;
    chk("run", {30'h0, continuous_run, scaler_enable}, 32'h3);
    chk("base a", frame_target_base, 32'h1000);
    chk("luma out", luma_base_out, 32'h12345674);
    chk("chroma u out", chroma_u_base_out, 32'h12345774);
    chk("chroma v out", chroma_v_base_out, 32'h12345874);
    chk("yuv mode", {31'h0, yuv_mode}, 32'h1);
    for (int k = 0; k < 3; k++)
      rchk("plane", 8'hD0 + 8'(4 * k), 32'h12345674 + (32'(k) << 8));
    src.frame(0, 2, 1'h1, 16'h0004);
    settle;
    chk("base b", frame_target_base, 32'h2000);
    src.frame(0, 2, 1'h1, 16'h0004);
    settle;
    chk("base a again", frame_target_base, 32'h1000);
    rchk("peak cleared", 8'hB0, 32'h00000005);
    bus(8'h80, 1'h1, 32'h0);
    settle;
    chk("luma off", luma_base_out, 32'h0);
    chk("chroma u off", chroma_u_base_out, 32'h0);
    chk("chroma v off", chroma_v_base_out, 32'h0);
    bus(8'h80, 1'h1, 32'h1);
    $display("test buffers done");
    bus(8'h90, 1'h1, 32'h00000800);
    bus(8'hD0, 1'h1, 32'hABCD0000);
    settle;
    chk("luma held", luma_base_out, 32'h12345674);
    src.vs;
    settle;
    chk("luma vsync", luma_base_out, 32'hABCD0000);
    bus(8'hD0, 1'h1, 32'h11111110);
    bus(8'h04, 1'h1, 32'hF);
    settle;
    chk("luma enable", luma_base_out, 32'h11111110);
    bus(8'h90, 1'h1, 32'h0);
    bus(8'hD0, 1'h1, 32'h55555554);
    settle;
    chk("luma direct", luma_base_out, 32'h55555554);
    chk("force v off", {31'h0, force_vertical_pass}, 32'h0);
    $display("test double buffer done");
    bus(8'h90, 1'h1, 32'h30001400);
    settle;
    chk("force h on", {31'h0, force_horizontal_pass}, 32'h1);
    p = pulses;
    src.frame(0, 2, 1'h0, 16'h0004);
    src.frame(0, 2, 1'h0, 16'h0004);
    repeat (20) @(posedge sys_clk);
    chk("pulse width", pulses - p, 32'h4);
    src.frame(0, 2, 1'h1, 16'h0004);
    $display("test overrun done");
    end_sim;
  end
endmodule // testbench
`default_nettype wire
